// [hdl/acc_conversion_control.sv]
// Converter control: register slave, clock select and divide, triggers, result transfer, pin disable.
// Operation
// - Upper pin disable bits govern channels 16-23.
// - Converter disabled in reset or channel all ones.
// - Idle at lowest power after finished conversion.
// - Sequence yields 11-bit or 9-bit raw code.
// - Round to ten or eight bits, place results.
// - Flag sets after transfer; interrupt per enable.
// - Compare enable bit turns on result comparison.
// - Four clock sources; bus clock after reset.
// - Source field codes bus, half, alternate, async.
// - Divide selected source by 1, 2, 4, 8.
// - Divider field codes 1, 2, 4, 8.
// - Async clock keeps running in wait, stop3.
// - Disabled pin: output hi-Z, pullup off.
// - Disabled pin: input off, reads zero.
// - Enabled hardware trigger rising edge starts conversion.
// - Trigger edge during conversion is ignored.
// - Continuous mode honours only the launching edge.
// - Mode field picks 10-bit or 8-bit.
// - Mode 00 eight bit, 10 ten bit.
// - Control write starts conversion unless channel off or hardware trigger enabled.
// - Continuous mode restarts after each transfer.
// - Half-read pair blocks transfer; flag stays clear.
// - After block, restart unless single failing compare.
`timescale 1ns/1ns
module acc_conversion_control
    import acc_pkg::*;
#(
    parameter logic [7:0] ASYNC_DIV = ASYNC_DIV_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    input  wire logic        comparator_out,
    output logic [10:0]      sar_dac_code,
    output logic [4:0]       channel_select,
    output logic             converter_enable,
    output logic             async_clock_enable,
    input  wire logic        alternate_clock,
    input  wire logic        hw_trigger_input,
    input  wire logic        stop_mode,
    output logic             conversion_irq,
    input  wire logic [7:0]  gpio_out_en,
    input  wire logic [7:0]  gpio_pullup,
    input  wire logic [7:0]  pad_in,
    output logic [7:0]       pad_oe_n,
    output logic [7:0]       pad_pullup_en,
    output logic [7:0]       pad_input_en,
    output logic [7:0]       gpio_read
);
    acc_regs_t   s;
    acc_regs_t   next_s;
    logic        do_write;
    logic        do_read;
    logic [7:0]  rd_addr;
    logic        wr_sc1;
    logic        ctrl_wr;
    logic        ten_bit;
    logic        hw_edge;
    logic        alt_edge;
    logic        async_run;
    logic        async_tick;
    logic        stop_abort;
    logic        src_tick;
    logic [2:0]  div_mask;
    logic        ck_en;
    logic        abort;
    logic        sw_start;
    logic        hw_start;
    logic        eng_start;
    logic        eng_done;
    logic [10:0] raw;
    logic [9:0]  rnd10;
    logic [7:0]  rnd8;
    logic [9:0]  result;
    logic [9:0]  cmp_ref;
    logic [9:0]  stored;
    logic        cond;
    logic        blocked;
    logic        transfer;
    logic        restart;
    logic [31:0] rword;

    assign do_write = s.aw_got && s.w_got && !s.bvalid;
    assign do_read  = s_axi_arvalid && !s.rvalid;
    assign rd_addr  = {s_axi_araddr[7:2], 2'b00};
    assign wr_sc1   = do_write && s.waddr == ACC_SC1 && s.wstrb[0];
    // A change of mode or compare value makes the running conversion meaningless.
    assign ctrl_wr  = do_write && (s.waddr == ACC_SC2 || s.waddr == ACC_CFG || s.waddr == ACC_CMPV);
    assign ten_bit  = s.mode == MODE_10;
    assign hw_edge  = s.trig_sync[1] && !s.trig_prev;
    assign alt_edge = s.alt_sync[1] && !s.alt_prev;

    // The internal clock runs only while converting, and ignores stop mode.
    assign async_run  = s.clk_sel == CLK_ASYNC && s.state == ACC_CONV;
    assign async_tick = async_run && s.async_cnt == ASYNC_DIV - 8'h01;
    assign stop_abort = stop_mode && s.clk_sel != CLK_ASYNC;

    always_comb begin
        case (s.clk_sel)
            CLK_BUS:   src_tick = 1'b1;
            CLK_BUS2:  src_tick = s.half;
            CLK_ALT:   src_tick = alt_edge;
            CLK_ASYNC: src_tick = async_tick;
            default:   src_tick = 1'b0;
        endcase
    end

    assign div_mask = 3'((4'h1 << s.div_sel) - 4'h1);
    assign ck_en    = src_tick && !stop_abort && (s.div_cnt & div_mask) == div_mask;

    assign abort    = wr_sc1 || ctrl_wr || stop_abort || s.channel == CH_OFF;
    assign sw_start = wr_sc1 && s.wdata[CH_W-1:0] != CH_OFF && !s.hw_en;
    // Edges while a conversion or a continuous run is under way are dropped.
    assign hw_start = hw_edge && s.hw_en && s.state == ACC_IDLE && s.channel != CH_OFF;

    acc_sar_engine u_sar (
        .clk            (clk),
        .rst            (rst),
        .start          (eng_start),
        .abort          (abort),
        .step           (ck_en),
        .ten_bit        (ten_bit),
        .comparator_out (comparator_out),
        .dac_code       (sar_dac_code),
        .done           (eng_done),
        .raw            (raw)
    );

    // Rounding saturates so a full-scale code does not wrap to zero.
    assign rnd10   = (&raw[10:1]) ? raw[10:1] : raw[10:1] + {9'h000, raw[0]};
    assign rnd8    = (&raw[10:3]) ? raw[10:3] : raw[10:3] + {7'h00, raw[2]};
    assign result  = ten_bit ? rnd10 : {2'b00, rnd8};
    assign cmp_ref = ten_bit ? s.cmp_val : {2'b00, s.cmp_val[7:0]};
    assign cond    = !s.cmp_en || (s.cmp_gt ? result >= cmp_ref : result < cmp_ref);
    assign stored  = s.cmp_en ? result - cmp_ref : result;
    assign blocked = ten_bit && s.hi_read;
    assign transfer = eng_done && !abort && cond && !blocked;
    assign restart  = s.cont_en || (blocked && cond);
    assign eng_start = sw_start || hw_start || (eng_done && !abort && restart);

    always_comb begin
        rword = '0;
        case (rd_addr)
            ACC_SC1: begin
                rword[SC1_CONVERSION_COMPLETE_FLAG]   = s.conversion_complete_flag;
                rword[SC1_IRQEN]  = s.irq_en;
                rword[SC1_CONT]   = s.cont_en;
                rword[CH_W-1:0]   = s.channel;
            end
            ACC_SC2: begin
                rword[SC2_BUSY]   = s.state == ACC_CONV;
                rword[SC2_HWEN]   = s.hw_en;
                rword[SC2_CMPEN]  = s.cmp_en;
                rword[SC2_CMPGT]  = s.cmp_gt;
            end
            ACC_CFG: begin
                rword[CFG_DIV+:2]  = s.div_sel;
                rword[CFG_MODE+:2] = s.mode;
                rword[CFG_CLK+:2]  = s.clk_sel;
            end
            ACC_RESH: rword[1:0]       = s.res_h;
            ACC_RESL: rword[7:0]       = s.res_l;
            ACC_CMPV: rword[CMP_W-1:0] = s.cmp_val;
            ACC_PIN:  rword[7:0]       = s.pin_dis;
            default:  rword = '0;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.trig_sync = {s.trig_sync[0], hw_trigger_input};
        next_s.trig_prev = s.trig_sync[1];
        next_s.alt_sync  = {s.alt_sync[0], alternate_clock};
        next_s.alt_prev  = s.alt_sync[1];
        next_s.pin_s1    = pad_in;
        next_s.pin_s2    = s.pin_s1;
        next_s.half      = !s.half;
        if (src_tick) begin
            next_s.div_cnt = s.div_cnt + 3'h1;
        end
        next_s.async_cnt = (!async_run || async_tick) ? 8'h00 : s.async_cnt + 8'h01;

        if (s_axi_awvalid && !s.aw_got && !s.bvalid) begin
            next_s.aw_got = 1'b1;
            next_s.waddr  = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && !s.w_got && !s.bvalid) begin
            next_s.w_got = 1'b1;
            next_s.wdata = s_axi_wdata;
            next_s.wstrb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end
        if (do_write) begin
            next_s.aw_got = 1'b0;
            next_s.w_got  = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_OKAY;
            case (s.waddr)
                ACC_SC1: if (s.wstrb[0]) begin
                    next_s.channel = s.wdata[CH_W-1:0];
                    next_s.irq_en  = s.wdata[SC1_IRQEN];
                    next_s.cont_en = s.wdata[SC1_CONT];
                    next_s.conversion_complete_flag    = 1'b0;
                end
                ACC_SC2: if (s.wstrb[0]) begin
                    next_s.hw_en  = s.wdata[SC2_HWEN];
                    next_s.cmp_en = s.wdata[SC2_CMPEN];
                    next_s.cmp_gt = s.wdata[SC2_CMPGT];
                end
                ACC_CFG: if (s.wstrb[0]) begin
                    next_s.div_sel = s.wdata[CFG_DIV+:2];
                    next_s.mode    = s.wdata[CFG_MODE+:2];
                    next_s.clk_sel = s.wdata[CFG_CLK+:2];
                end
                ACC_CMPV: begin
                    if (s.wstrb[0]) begin
                        next_s.cmp_val[7:0] = s.wdata[7:0];
                    end
                    if (s.wstrb[1]) begin
                        next_s.cmp_val[CMP_W-1:8] = s.wdata[CMP_W-1:8];
                    end
                end
                ACC_PIN: if (s.wstrb[0]) begin
                    next_s.pin_dis = s.wdata[7:0];
                end
                ACC_RESH, ACC_RESL: next_s.bresp = RESP_OKAY;
                default: next_s.bresp = RESP_SLVERR;
            endcase
        end

        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
        if (do_read) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rword;
            next_s.rresp  = (rd_addr <= ACC_PIN) ? RESP_OKAY : RESP_SLVERR;
            // Reading the upper half of a 10-bit pair arms the transfer block until the lower half is read.
            if (rd_addr == ACC_RESH && ten_bit) begin
                next_s.hi_read = 1'b1;
            end
            if (rd_addr == ACC_RESL) begin
                next_s.hi_read = 1'b0;
                next_s.conversion_complete_flag    = 1'b0;
            end
        end

        // A completion in the same cycle as a lower-half read still leaves the flag set.
        if (transfer) begin
            next_s.res_h    = ten_bit ? stored[9:8] : 2'b00;
            next_s.res_l    = stored[7:0];
            next_s.conversion_complete_flag     = 1'b1;
            next_s.irq_flag = s.irq_en;
        end

        if (eng_start) begin
            next_s.state = ACC_CONV;
        end else if (abort || (eng_done && !restart)) begin
            next_s.state = ACC_IDLE;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
            s.channel <= CH_RESET;
            s.clk_sel <= CLK_BUS;
            s.pin_dis <= PIN_RESET;
            s.state   <= ACC_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready      = !s.aw_got && !s.bvalid;
    assign s_axi_wready       = !s.w_got && !s.bvalid;
    assign s_axi_bvalid       = s.bvalid;
    assign s_axi_bresp        = s.bresp;
    assign s_axi_arready      = !s.rvalid;
    assign s_axi_rvalid       = s.rvalid;
    assign s_axi_rdata        = s.rdata;
    assign s_axi_rresp        = s.rresp;
    assign channel_select     = s.channel;
    assign converter_enable   = s.state == ACC_CONV;
    assign async_clock_enable = async_run;
    assign conversion_irq     = s.conversion_complete_flag && s.irq_flag;

    for (genvar gi = 0; gi < 8; gi++) begin : g_pin
        assign pad_oe_n[gi]      = !(gpio_out_en[gi] && !s.pin_dis[gi]);
        assign pad_pullup_en[gi] = gpio_pullup[gi] && !s.pin_dis[gi];
        assign pad_input_en[gi]  = !s.pin_dis[gi];
        assign gpio_read[gi]     = s.pin_s2[gi] && !s.pin_dis[gi];
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    property p_off_idle;
        s.channel == CH_OFF |-> s.state == ACC_IDLE && !converter_enable;
    endproperty
    a_off_idle: assert property (p_off_idle) else $error("converter active with channel off");

    property p_idle_after;
        eng_done && !restart && !eng_start |=> s.state == ACC_IDLE;
    endproperty
    a_idle_after: assert property (p_idle_after) else $error("not idle after final conversion");

    property p_round10;
        transfer && ten_bit && !s.cmp_en |=> {s.res_h, s.res_l} == $past(rnd10);
    endproperty
    a_round10: assert property (p_round10) else $error("10-bit result not placed");

    property p_flag_irq;
        transfer |=> s.conversion_complete_flag && s.irq_flag == $past(s.irq_en) && conversion_irq == $past(s.irq_en);
    endproperty
    a_flag_irq: assert property (p_flag_irq) else $error("flag or interrupt wrong after transfer");

    property p_reset_bus;
        $past(rst) |-> s.clk_sel == CLK_BUS;
    endproperty
    a_reset_bus: assert property (p_reset_bus) else $error("bus clock not selected after reset");

    property p_div8;
        ck_en && s.clk_sel == CLK_BUS && s.div_sel == 2'h3 |=> (!ck_en || s.div_sel != 2'h3)[*7];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight spacing wrong");

    property p_pins;
        (~pad_oe_n & s.pin_dis) == 8'h00 && (pad_pullup_en & s.pin_dis) == 8'h00;
    endproperty
    a_pins: assert property (p_pins) else $error("disabled pin still driven or pulled up");

    property p_read_zero;
        (gpio_read & s.pin_dis) == 8'h00 && (pad_input_en & s.pin_dis) == 8'h00;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("disabled pin input not zero");

    property p_hw_start;
        hw_edge && s.hw_en && s.state == ACC_IDLE && s.channel != CH_OFF && !ctrl_wr |=> s.state == ACC_CONV;
    endproperty
    a_hw_start: assert property (p_hw_start) else $error("trigger edge did not start");

    property p_sw_start;
        sw_start |=> s.state == ACC_CONV ##1 u_sar.s.busy;
    endproperty
    a_sw_start: assert property (p_sw_start) else $error("control write did not start");

    property p_blocked;
        eng_done && blocked && !abort |=> $stable(s.res_l) && $stable(s.res_h) && !$rose(s.conversion_complete_flag);
    endproperty
    a_blocked: assert property (p_blocked) else $error("blocked result was transferred");

    c_transfer: cover property (transfer && ten_bit);
    c_blocked:  cover property (eng_done && blocked && s.state == ACC_CONV);
    c_hw:       cover property (hw_start);
    c_cont:     cover property (transfer && s.cont_en ##1 s.state == ACC_CONV);
endmodule // acc_conversion_control

// [hdl/acc_pkg.sv]
// Shared constants and state types of the converter control block.
package acc_pkg;
    localparam logic [7:0] ACC_SC1  = 8'h00;
    localparam logic [7:0] ACC_SC2  = 8'h04;
    localparam logic [7:0] ACC_CFG  = 8'h08;
    localparam logic [7:0] ACC_RESH = 8'h0C;
    localparam logic [7:0] ACC_RESL = 8'h10;
    localparam logic [7:0] ACC_CMPV = 8'h14;
    localparam logic [7:0] ACC_PIN  = 8'h18;

    localparam int SC1_CONVERSION_COMPLETE_FLAG  = 7;
    localparam int SC1_IRQEN = 6;
    localparam int SC1_CONT  = 5;
    localparam int SC2_BUSY  = 7;
    localparam int SC2_HWEN  = 6;
    localparam int SC2_CMPEN = 5;
    localparam int SC2_CMPGT = 4;
    localparam int CFG_DIV   = 5;
    localparam int CFG_MODE  = 2;
    localparam int CFG_CLK   = 0;
    localparam int CH_W      = 5;
    localparam int CMP_W     = 10;
    localparam int SAR_W     = 11;

    localparam logic [4:0]  CH_OFF      = 5'h1F;
    localparam logic [4:0]  CH_RESET    = 5'h1F;
    localparam logic [7:0]  PIN_RESET   = 8'h00;
    localparam logic [1:0]  CLK_BUS     = 2'h0;
    localparam logic [1:0]  CLK_BUS2    = 2'h1;
    localparam logic [1:0]  CLK_ALT     = 2'h2;
    localparam logic [1:0]  CLK_ASYNC   = 2'h3;
    localparam logic [1:0]  MODE_10     = 2'h2;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [3:0]  SAR_TOP     = 4'hA;
    localparam logic [3:0]  SAR_STOP10  = 4'h0;
    localparam logic [3:0]  SAR_STOP8   = 4'h2;
    localparam logic [10:0] SAR_FIRST   = 11'h400;
    localparam logic [7:0]  ASYNC_DIV_DEF = 8'h04;

    typedef enum logic {ACC_IDLE, ACC_CONV} acc_state_t;

    typedef struct packed {
        logic [10:0] code;
        logic [3:0]  idx;
        logic        busy;
        logic        done;
    } acc_sar_t;

    typedef struct packed {
        logic        aw_got;
        logic        w_got;
        logic [7:0]  waddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [4:0]  channel;
        logic        irq_en;
        logic        cont_en;
        logic        conversion_complete_flag;
        logic        irq_flag;
        logic        hw_en;
        logic        cmp_en;
        logic        cmp_gt;
        logic [1:0]  div_sel;
        logic [1:0]  mode;
        logic [1:0]  clk_sel;
        logic [9:0]  cmp_val;
        logic [1:0]  res_h;
        logic [7:0]  res_l;
        logic [7:0]  pin_dis;
        logic        hi_read;
        acc_state_t  state;
        logic        half;
        logic [2:0]  div_cnt;
        logic [7:0]  async_cnt;
        logic [1:0]  trig_sync;
        logic        trig_prev;
        logic [1:0]  alt_sync;
        logic        alt_prev;
        logic [7:0]  pin_s1;
        logic [7:0]  pin_s2;
    } acc_regs_t;
endpackage

// [hdl/acc_sar_engine.sv]
// Successive approximation sequencer, one trial bit per converter clock.
`timescale 1ns/1ns
module acc_sar_engine
    import acc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic        step,
    input  wire logic        ten_bit,
    input  wire logic        comparator_out,
    output logic [10:0]      dac_code,
    output logic             done,
    output logic [10:0]      raw
);
    acc_sar_t s;
    acc_sar_t next_s;

    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        if (start) begin
            next_s.busy = 1'b1;
            next_s.code = SAR_FIRST;
            next_s.idx  = SAR_TOP;
        end else if (abort) begin
            next_s.busy = 1'b0;
        end else if (s.busy && step) begin
            if (!comparator_out) begin
                next_s.code[s.idx] = 1'b0;
            end
            // Eight-bit mode stops two trials early, leaving a 9-bit code in the top bits.
            if (s.idx == (ten_bit ? SAR_STOP10 : SAR_STOP8)) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end else begin
                next_s.idx = s.idx - 4'h1;
                next_s.code[s.idx - 4'h1] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign dac_code = s.code;
    assign done     = s.done;
    assign raw      = s.code;
endmodule // acc_sar_engine

// [test/acc_analog_model.sv]
// Analog channel and comparator model standing behind the converter's trial code.
`timescale 1ns/1ns
module acc_analog_model (
    input  wire logic        clk,
    input  wire logic [10:0] level,
    input  wire logic [10:0] sar_dac_code,
    input  wire logic        converter_enable,
    output logic             comparator_out
);
    logic wobble = 1'b0;
    // The input sits half a step above level, so an equal trial code is kept.
    // While idle the comparator output wanders, so a stale value cannot be trusted.
    always @(posedge clk) wobble <= ~wobble;
    assign comparator_out = converter_enable ? (level >= sar_dac_code) : wobble;
endmodule // acc_analog_model

// [test/tb.sv]
// Self-checking bench for the converter control block.
`timescale 1ns/1ns
module tb;
    import acc_pkg::*;
    logic        clk, rst, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, cmp, cen, ace, irq, trig, alt, stp;
    logic [7:0]  awa, ara, oe, pu, pin, p, oen, pue, ine, grd;
    logic [31:0] wd, rd, q;
    logic [10:0] dac, lvl;
    logic [4:0]  chs;
    logic [1:0]  bresp, rresp, lb, lr;
    int          error_cnt = 0, checks_done = 0, cyc = 0, n, md, e;

    acc_conversion_control #(.ASYNC_DIV(8'h04)) u_acc_conversion_control (
        .clk(clk), .rst(rst), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .comparator_out(cmp), .sar_dac_code(dac),
        .channel_select(chs), .converter_enable(cen), .async_clock_enable(ace),
        .alternate_clock(alt), .hw_trigger_input(trig), .stop_mode(stp), .conversion_irq(irq),
        .gpio_out_en(oe), .gpio_pullup(pu), .pad_in(pin), .pad_oe_n(oen), .pad_pullup_en(pue),
        .pad_input_en(ine), .gpio_read(grd));
    acc_analog_model u_acc_analog_model (.clk(clk), .level(lvl), .sar_dac_code(dac),
        .converter_enable(cen), .comparator_out(cmp));

    task chk(input logic [31:0] s, input logic [31:0] x);
        checks_done++;
        if (s !== x) begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, s, x);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        lb = bresp;
    endtask
    task rdr(input logic [7:0] a);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        do begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        q = rd;
        lr = rresp;
    endtask
    // Only the control register is polled, so no result read disturbs a running conversion.
    task wait_done;
        n = 0;
        do begin
            rdr(ACC_SC1);
            n++;
        end while (!q[SC1_CONVERSION_COMPLETE_FLAG] && n < 3000);
        chk(32'(q[SC1_CONVERSION_COMPLETE_FLAG]), 32'h1);
    endtask
    task wrap_up;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // The alternate source runs at an unrelated rate and phase.
    initial begin
        alt = 1'b0;
        #1;
        forever #17 alt = ~alt;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            wrap_up;
        end
    end

    initial begin
        rst = 1'b1; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0; awa = 8'h00; ara = 8'h00;
        wd = 32'h0; trig = 1'b0; lvl = 11'h000; oe = 8'h00; pu = 8'h00; pin = 8'h00; stp = 1'b0;
        void'($urandom(32'h85A0));
        repeat (20) @(posedge clk);
        chk(32'(cen), 32'h0);
        rst <= 1'b0;
        @(posedge clk);
        rdr(ACC_SC1); chk(q, 32'h1F);
        rdr(ACC_CFG); chk(q, 32'h0);
        rdr(ACC_PIN); chk(q, 32'h0);
        oe <= 8'($urandom); pu <= 8'($urandom); pin <= 8'($urandom); p = 8'($urandom);
        wr(ACC_PIN, 32'(p));
        repeat (3) @(posedge clk);
        chk({oen, pue, ine, grd}, {~oe | p, pu & ~p, ~p, pin & ~p});
        for (int i = 0; i < 8; i++) begin
            md = (i < 4) ? 2 : 0;
            wr(ACC_CFG, 32'((i % 4) * 32 + md * 4 + (i + 1) % 4));
            // Stop mode is held during internal-clock conversions, which must still finish.
            stp <= ((i + 1) % 4 == 3);
            // Full-range levels exercise rounding carries and saturation at full scale.
            lvl <= 11'($urandom);
            wr(ACC_SC1, 32'((i % 2) * 64 + 16 + i));
            chk(32'(ace), 32'((i + 1) % 4 == 3));
            wait_done;
            chk(32'(irq), 32'(i % 2));
            chk(32'(chs), 32'(16 + i));
            e = (md == 2) ? (lvl + 1) / 2 : (lvl / 4 + 1) / 2;
            if (md == 2 && e > 1023) e = 1023;
            if (md == 0 && e > 255) e = 255;
            if (md == 2) begin
                rdr(ACC_RESH); chk(q, 32'(e / 256));
            end
            rdr(ACC_RESL); chk(q, 32'(e % 256));
        end
        wr(ACC_SC1, 32'h1F);
        repeat (4) @(posedge clk);
        chk(32'(cen), 32'h0);
        wr(ACC_SC2, 32'h40);
        wr(ACC_SC1, 32'h05);
        repeat (5) @(posedge clk);
        chk(32'(cen), 32'h0);
        trig <= 1'b1;
        repeat (8) @(posedge clk);
        trig <= 1'b0;
        repeat (4) @(posedge clk);
        trig <= 1'b1;
        wait_done;
        repeat (100) @(posedge clk);
        chk(32'(cen), 32'h0);
        wr(ACC_SC2, 32'h0);
        // Stop mode with a bus-derived clock must abort the running conversion.
        wr(ACC_CFG, 32'h60);
        wr(ACC_SC1, 32'h05);
        stp <= 1'b1;
        repeat (4) @(posedge clk);
        chk(32'(cen), 32'h0);
        stp <= 1'b0;
        wr(ACC_CFG, 32'h08);
        wr(ACC_SC1, 32'h05);
        wait_done;
        rdr(ACC_RESH);
        wr(ACC_SC1, 32'h05);
        repeat (60) @(posedge clk);
        rdr(ACC_SC1); chk(q, 32'h05);
        chk(32'(cen), 32'h1);
        rdr(ACC_RESL);
        wait_done;
        wr(ACC_SC1, 32'h25);
        wait_done;
        rdr(ACC_RESL);
        wait_done;
        wr(ACC_SC1, 32'h1F);
        lvl <= 11'h500;
        wr(ACC_CMPV, 32'h100);
        wr(ACC_SC2, 32'h30);
        wr(ACC_SC1, 32'h05);
        wait_done;
        rdr(ACC_RESH); chk(q, 32'h1);
        rdr(ACC_RESL); chk(q, 32'h80);
        wr(ACC_SC2, 32'h20);
        rdr(ACC_RESH);
        wr(ACC_SC1, 32'h05);
        repeat (40) @(posedge clk);
        rdr(ACC_SC1); chk(q, 32'h05);
        chk(32'(cen), 32'h0);
        wr(8'h1C, 32'h1); chk(32'(lb), 32'(RESP_SLVERR));
        rdr(8'h1C); chk(q, 32'h0); chk(32'(lr), 32'(RESP_SLVERR));
        wrap_up;
    end
endmodule // tb
